// [logic/scan_output_pkg.sv]
package scan_output_pkg;

	// Output organisation
	localparam int GROUPS  = 4;	// Output groups per module
	localparam int GROUP_W = 8;	// Points per group
	localparam int BLOCK_W = 5;	// Width of the 32-bit block index
	localparam int SEL_W   = 2;	// Width of the group number

	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] REG_CTRL     = 8'h00;	// Mode selects
	localparam logic [7:0] REG_STATUS   = 8'h04;	// Supplies, fault, alarm
	localparam logic [7:0] REG_OUTPUTS  = 8'h08;	// Field output states
	localparam logic [7:0] REG_IRQ_STAT = 8'h0c;	// Sticky events, write one to clear
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;	// Event enables
	localparam logic [7:0] REG_SLOT     = 8'h14;	// Slot switch block index

	// Control fields
	localparam int CTRL_W          = 2;
	localparam int CTRL_HOLD_BIT   = 0;	// 1: hold last state, 0: disable outputs
	localparam int CTRL_INVERT_BIT = 1;	// 1: inverted data, 0: normal
	localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

	// Status fields
	localparam int STAT_LOW_BIT   = 0;	// Supply for groups 1 and 2 present
	localparam int STAT_HIGH_BIT  = 1;	// Supply for groups 3 and 4 present
	localparam int STAT_FAULT_BIT = 2;	// Controller fault active
	localparam int STAT_ALARM_BIT = 3;	// Supply alarm active

	// Interrupt fields
	localparam int IRQ_W         = 3;
	localparam int IRQ_ALARM_BIT = 0;	// Supply alarm raised
	localparam int IRQ_FAULT_BIT = 1;	// Controller fault began
	localparam int IRQ_BLOCK_BIT = 2;	// All four groups delivered
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

	// Bus slave states
	typedef enum logic [1:0] {
		WB_IDLE = 2'b01,
		WB_ACK  = 2'b10
	} wb_state_t;

endpackage

// [logic/group_latch.sv]
// One group of output points: holds the ON state of each point
module group_latch #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Control
	input  wire logic             load,
	input  wire logic             clear,
	input  wire logic [WIDTH-1:0] din,
	// Held ON states
	output      logic [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] onBits;	// ON state per point
	} latch_t;

	latch_t cur_r;	// Registered state
	latch_t cur_nxt;	// Next state

	// Clear beats load so a lost supply never lets data through
	always_comb begin
		cur_nxt = cur_r;
		if (clear) begin
			cur_nxt.onBits = '0;
		end else if (load) begin
			cur_nxt.onBits = din;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_r <= '0;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign q = cur_r.onBits;

endmodule // group_latch

// [logic/scan_output_port_32.sv]
module scan_output_port_32 #(
	parameter int GROUPS  = scan_output_pkg::GROUPS,
	parameter int GROUP_W = scan_output_pkg::GROUP_W
) (
	// Clock and reset
	input  wire logic                                clk,
	input  wire logic                                rst,
	// Wishbone slave
	input  wire logic                                wbCyc,
	input  wire logic                                wbStb,
	input  wire logic                                wbWe,
	input  wire logic [7:0]                          wbAdr,
	input  wire logic [3:0]                          wbSel,
	input  wire logic [31:0]                         wbDatW,
	output      logic [31:0]                         wbDatR,
	output      logic                                wbAck,
	// Backplane scan delivery
	input  wire logic                                scanStb,
	input  wire logic [scan_output_pkg::BLOCK_W-1:0] scanBlock,
	input  wire logic [scan_output_pkg::SEL_W-1:0]   scanGroup,
	input  wire logic [GROUP_W-1:0]                  scanData,
	input  wire logic                                sysFault,
	// Slot switches seven down to three, open reads as one
	input  wire logic [scan_output_pkg::BLOCK_W-1:0] slotSwitch,
	// User supplies, high while present
	input  wire logic                                supplyGroupsLow,
	input  wire logic                                supplyGroupsHigh,
	// Field side and indicators
	output      logic [GROUPS*GROUP_W-1:0]           fieldOut,
	output      logic [GROUPS*GROUP_W-1:0]           ledOut,
	output      logic                                ledHold,
	output      logic                                ledInvert,
	output      logic                                alarm,
	output      logic                                irq
);

	localparam int OUT_W = GROUPS * GROUP_W;	// Total output points

	// All state of the port outside the group latches
	typedef struct packed {
		scan_output_pkg::wb_state_t                  wbState;	// Bus slave phase
		logic                                        ack;	// Bus answer
		logic [31:0]                                 rdat;	// Read data held with ack
		logic [scan_output_pkg::CTRL_W-1:0]          ctrl;	// Mode selects
		logic [scan_output_pkg::IRQ_W-1:0]           irqStat;	// Sticky events
		logic [scan_output_pkg::IRQ_W-1:0]           irqMask;	// Event enables
		logic [GROUPS-1:0]                           seen;	// Groups delivered this scan
		logic                                        prevFault;	// Fault edge detect
		logic                                        alarm;	// Supply alarm
		logic                                        ledHold;	// Hold mode indicator
		logic                                        ledInvert;	// Invert mode indicator
		logic                                        irq;	// Interrupt line
	} port_t;

	port_t cur_r;	// Registered state
	port_t cur_nxt;	// Next state

	logic              holdMode;	// Hold last state selected
	logic              invertMode;	// Inverted data selected
	logic              supplyOk;	// Both user supplies present
	logic              blockHit;	// Delivery addressed to this slot
	logic              clearAll;	// Force every point off
	logic [GROUPS-1:0] loadVec;	// Per-group latch strobe
	logic [OUT_W-1:0]  onState;	// Held ON states of all points
	logic [GROUP_W-1:0] groupDin;	// Delivered byte after polarity

	// True when the scan addresses the block set on the slot switches
	function automatic logic block_match(
		input logic [scan_output_pkg::BLOCK_W-1:0] blk,
		input logic [scan_output_pkg::BLOCK_W-1:0] sw
	);
		return blk == sw;
	endfunction

	assign holdMode   = cur_r.ctrl[scan_output_pkg::CTRL_HOLD_BIT];
	assign invertMode = cur_r.ctrl[scan_output_pkg::CTRL_INVERT_BIT];
	assign supplyOk   = supplyGroupsLow & supplyGroupsHigh;

	assign blockHit = scanStb & block_match(scanBlock, slotSwitch);

	// polarity applied
	// Latches keep ON states, so an off point is zero in either polarity
	assign groupDin = scanData ^ {GROUP_W{invertMode}};

	// clear conditions
	// A missing supply also ends a held state, as power is gone anyway
	assign clearAll = ~supplyOk | (sysFault & ~holdMode);

	// One latch per group
	genvar g;
	generate
		for (g = 0; g < GROUPS; g++) begin : gen_group
			// group load
			// Deliveries during a fault are not valid data and are ignored
			assign loadVec[g] = blockHit & ~sysFault
				& (scanGroup == (scan_output_pkg::SEL_W)'(g));
			group_latch #(
				.WIDTH (GROUP_W)
			) u_latch (
				.clk   (clk),
				.rst   (rst),
				.load  (loadVec[g]),
				.clear (clearAll),
				.din   (groupDin),
				.q     (onState[g*GROUP_W +: GROUP_W])
			);
		end
	endgenerate

	// Next state: bus slave, events, indicators
	always_comb begin
		logic [scan_output_pkg::IRQ_W-1:0] evt;	// Events this cycle
		logic [scan_output_pkg::IRQ_W-1:0] clr;	// Write-one-to-clear bits
		logic [GROUPS-1:0]                 seenNow;	// Groups seen incl. this cycle
		logic                              alarmNow;	// Supply missing now
		evt      = '0;
		clr      = '0;
		seenNow  = cur_r.seen | loadVec;
		alarmNow = ~supplyOk;
		cur_nxt  = cur_r;

		if (&seenNow) begin
			evt[scan_output_pkg::IRQ_BLOCK_BIT] = 1'b1;
			cur_nxt.seen = '0;
		end else begin
			cur_nxt.seen = seenNow;
		end

		cur_nxt.alarm = alarmNow;
		evt[scan_output_pkg::IRQ_ALARM_BIT] = alarmNow & ~cur_r.alarm;
		evt[scan_output_pkg::IRQ_FAULT_BIT] = sysFault & ~cur_r.prevFault;
		cur_nxt.prevFault = sysFault;

		// Bus slave: take in idle, answer for one cycle
		// Reads are captured at the taking edge; writes wait for the ack edge,
		// where the master still holds the request and sees the answer
		case (cur_r.wbState)
			scan_output_pkg::WB_IDLE: begin
				cur_nxt.ack = 1'b0;
				if (wbCyc && wbStb) begin
					cur_nxt.wbState = scan_output_pkg::WB_ACK;
					cur_nxt.ack     = 1'b1;
					cur_nxt.rdat    = '0;
					case (wbAdr)
						scan_output_pkg::REG_CTRL: begin
							cur_nxt.rdat[scan_output_pkg::CTRL_W-1:0] = cur_r.ctrl;
						end
						scan_output_pkg::REG_STATUS: begin
							cur_nxt.rdat[scan_output_pkg::STAT_LOW_BIT]   = supplyGroupsLow;
							cur_nxt.rdat[scan_output_pkg::STAT_HIGH_BIT]  = supplyGroupsHigh;
							cur_nxt.rdat[scan_output_pkg::STAT_FAULT_BIT] = sysFault;
							cur_nxt.rdat[scan_output_pkg::STAT_ALARM_BIT] = cur_r.alarm;
						end
						scan_output_pkg::REG_OUTPUTS: begin
							cur_nxt.rdat[OUT_W-1:0] = onState;
						end
						scan_output_pkg::REG_IRQ_STAT: begin
							cur_nxt.rdat[scan_output_pkg::IRQ_W-1:0] = cur_r.irqStat;
						end
						scan_output_pkg::REG_IRQ_MASK: begin
							cur_nxt.rdat[scan_output_pkg::IRQ_W-1:0] = cur_r.irqMask;
						end
						scan_output_pkg::REG_SLOT: begin
							cur_nxt.rdat[scan_output_pkg::BLOCK_W-1:0] = slotSwitch;
						end
						// Unmapped: answered, reads zero
						default: begin
							cur_nxt.rdat = '0;
						end
					endcase
				end
			end
			scan_output_pkg::WB_ACK: begin
				// Master releases after ack; never answer twice
				cur_nxt.ack     = 1'b0;
				cur_nxt.wbState = scan_output_pkg::WB_IDLE;
				// Writes land here; lane zero off means nothing is written
				if (wbCyc && wbStb && wbWe && wbSel[0]) begin
					case (wbAdr)
						scan_output_pkg::REG_CTRL: begin
							cur_nxt.ctrl = wbDatW[scan_output_pkg::CTRL_W-1:0];
						end
						scan_output_pkg::REG_IRQ_STAT: begin
							clr = wbDatW[scan_output_pkg::IRQ_W-1:0];
						end
						scan_output_pkg::REG_IRQ_MASK: begin
							cur_nxt.irqMask = wbDatW[scan_output_pkg::IRQ_W-1:0];
						end
						// Read-only and unmapped offsets drop writes
						default: begin
							cur_nxt.rdat = cur_r.rdat;
						end
					endcase
				end
			end
			default: begin
				cur_nxt.ack     = 1'b0;
				cur_nxt.wbState = scan_output_pkg::WB_IDLE;
			end
		endcase

		// Set wins over clear so no event is lost
		cur_nxt.irqStat = (cur_r.irqStat & ~clr) | evt;
		cur_nxt.irq     = |(cur_r.irqStat & cur_r.irqMask);

		cur_nxt.ledHold   = holdMode;
		cur_nxt.ledInvert = invertMode;
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_r           <= '0;
			cur_r.wbState   <= scan_output_pkg::WB_IDLE;
			cur_r.ctrl      <= scan_output_pkg::CTRL_RESET;
			cur_r.irqStat   <= scan_output_pkg::IRQ_RESET;
			cur_r.irqMask   <= scan_output_pkg::IRQ_RESET;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// outputs and indicators
	// Both come from the same latch flops, so a lamp never disagrees
	assign fieldOut  = onState;
	assign ledOut    = onState;
	assign ledHold   = cur_r.ledHold;
	assign ledInvert = cur_r.ledInvert;
	assign alarm     = cur_r.alarm;
	assign irq       = cur_r.irq;
	assign wbAck     = cur_r.ack;
	assign wbDatR    = cur_r.rdat;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_supply_off: assert property (!supplyOk |=> fieldOut == '0)
		else $error("outputs not off after supply loss");
	a_disable_fault: assert property ((sysFault && !holdMode) |=> fieldOut == '0)
		else $error("disable mode left outputs on during fault");
	a_hold_fault: assert property ((sysFault && holdMode && supplyOk) |=> $stable(fieldOut))
		else $error("hold mode changed outputs during fault");
	a_group_load: assert property ((blockHit && scanGroup == 2'h0 && !sysFault && supplyOk)
		|=> fieldOut[GROUP_W-1:0] == ($past(scanData) ^ {GROUP_W{$past(invertMode)}}))
		else $error("group one not loaded with polarity applied");
	a_foreign_block: assert property ((!blockHit && supplyOk && !sysFault) |=> $stable(fieldOut))
		else $error("outputs changed without a matching delivery");
	a_supply_alarm: assert property ((!supplyGroupsLow || !supplyGroupsHigh) |=> alarm)
		else $error("alarm not raised for missing supply");
	a_mode_leds: assert property ($changed(cur_r.ctrl) |=> ##1 (ledHold == $past(holdMode)
		&& ledInvert == $past(invertMode)))
		else $error("mode indicators do not follow selects");
	a_led_match: assert property (ledOut == fieldOut)
		else $error("indicator differs from output");
	a_scan_done: assert property ((blockHit && !sysFault && supplyOk && (&(cur_r.seen | loadVec)))
		|=> cur_r.irqStat[scan_output_pkg::IRQ_BLOCK_BIT])
		else $error("scan completion not flagged");
	a_bus_ack: assert property ((wbCyc && wbStb && !wbAck && cur_r.wbState == scan_output_pkg::WB_IDLE)
		|=> wbAck ##1 !wbAck)
		else $error("bus answer not one cycle");
	// Bus writes take effect only at the edge where ack is seen
	a_bus_write: assert property ((wbAck && wbCyc && wbStb && wbWe && wbSel[0]
		&& wbAdr == scan_output_pkg::REG_CTRL)
		|=> cur_r.ctrl == $past(wbDatW[scan_output_pkg::CTRL_W-1:0]))
		else $error("control write did not land at the ack edge");
	// Fault start is recorded as an event on its first cycle
	a_fault_event: assert property ((sysFault && !cur_r.prevFault)
		|=> cur_r.irqStat[scan_output_pkg::IRQ_FAULT_BIT])
		else $error("fault event not flagged");
	// Interrupt is a level, one cycle behind the unmasked status
	a_irq_level: assert property (irq == $past(|(cur_r.irqStat & cur_r.irqMask)))
		else $error("interrupt line does not follow unmasked status");

	// Main scenarios that the bench should reach

	c_hold_through: cover property (sysFault && holdMode && fieldOut != '0 ##1 sysFault);
	c_invert_load: cover property (blockHit && invertMode && !sysFault && supplyOk);
	c_alarm_irq: cover property (alarm ##[1:3] irq);
	c_full_scan: cover property (cur_r.irqStat[scan_output_pkg::IRQ_BLOCK_BIT]);
	c_invert_hold: cover property (holdMode && invertMode && blockHit && supplyOk);

endmodule // scan_output_port_32

// [tb/scan_cpu_model.sv]
// Controller side of the backplane scan: delivers group bytes and signals faults
module scan_cpu_model (
	// Clock
	input  wire logic       clk,
	// Scan delivery
	output      logic       scanStb,
	output      logic [4:0] scanBlock,
	output      logic [1:0] scanGroup,
	output      logic [7:0] scanData,
	output      logic       sysFault
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet bus at time zero
	initial begin
		scanStb   = 1'b0;
		scanBlock = 5'h00;
		scanGroup = 2'h0;
		scanData  = 8'h00;
		sysFault  = 1'b0;
	end

	// block index: caller passes the slot switch code of the target
	// raw bits: polarity is left to the module's own select
	task automatic send(input logic [4:0] blk, input logic [1:0] g, input logic [7:0] d);
		@(posedge clk);
		scanStb   <= 1'b1;
		scanBlock <= blk;
		scanGroup <= g;
		scanData  <= d;
	endtask

	// Released data line shows the inverse, so stale bytes cannot pass as valid
	task automatic idle();
		@(posedge clk);
		scanStb  <= 1'b0;
		scanData <= ~scanData;
	endtask

	// whole block: four groups back to back within one scan
	task automatic sendBlock(input logic [4:0] blk, input logic [31:0] d);
		for (int g = 0; g < 4; g++) begin
			send(blk, 2'(g), d[8*g +: 8]);
		end
		idle();
	endtask

	// Controller fault level, changed just after an edge
	task automatic fault(input logic v);
		@(posedge clk);
		sysFault <= v;
	endtask
endmodule // scan_cpu_model

// [tb/testbench.sv]
// Self-checking bench for the 32-point scan output port
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [1:0] ctrl;	// Mode selects written first
		logic [1:0] grp;	// Group delivered
		logic [7:0] dat;	// Commanded byte
		logic [7:0] exp;	// Expected field byte
	} row_t;

	logic        clk, rst, wbCyc, wbStb, wbWe, wbAck, alarm, irq;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatW, wbDatR, fieldOut, ledOut, rd;
	logic        scanStb, sysFault, supplyGroupsLow, supplyGroupsHigh, ledHold, ledInvert;
	logic [4:0]  scanBlock, slotSwitch;
	logic [1:0]  scanGroup;
	logic [7:0]  scanData;
	int          mismatches, nTests, cycles;
	row_t        rows [4];

	scan_output_port_32 scan_output_port_32_i (.clk(clk), .rst(rst), .wbCyc(wbCyc),
		.wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
		.wbDatR(wbDatR), .wbAck(wbAck), .scanStb(scanStb), .scanBlock(scanBlock),
		.scanGroup(scanGroup), .scanData(scanData), .sysFault(sysFault),
		.slotSwitch(slotSwitch), .supplyGroupsLow(supplyGroupsLow),
		.supplyGroupsHigh(supplyGroupsHigh), .fieldOut(fieldOut), .ledOut(ledOut),
		.ledHold(ledHold), .ledInvert(ledInvert), .alarm(alarm), .irq(irq));

	scan_cpu_model cpu_i (.clk(clk), .scanStb(scanStb), .scanBlock(scanBlock),
		.scanGroup(scanGroup), .scanData(scanData), .sysFault(sysFault));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			endOfTest();
		end
	end

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic single cycle: held until ack is sampled, then released for a cycle
	task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= we;
		wbAdr  <= a;
		wbSel  <= 4'hf;
		wbDatW <= d;
		do @(posedge clk); while (wbAck !== 1'b1);
		rd = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe  <= 1'b0;
	endtask

	// Let n edges pass, then look once outputs settled
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic endOfTest();
		$display("comparisons %0d mismatches %0d", nTests, mismatches);
		if (mismatches == 0 && nTests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		{rst, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = {1'b1, 47'h0};
		{supplyGroupsLow, supplyGroupsHigh, slotSwitch} = {2'b11, 5'h13};
		{mismatches, nTests, cycles} = {32'h0, 32'h0, 32'h0};
		// Every polarity and fault mode code once
		rows = '{'{2'h0, 2'h0, 8'ha5, 8'ha5}, '{2'h2, 2'h1, 8'ha5, 8'h5a},
			'{2'h1, 2'h2, 8'h0f, 8'h0f}, '{2'h3, 2'h3, 8'h00, 8'hff}};
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		check(fieldOut, 32'h0);
		wbXfer(1'b0, scan_output_pkg::REG_CTRL, 32'h0);
		check(rd, 32'h0);
		$display("test reset done");
		// Ordinary deliveries, one row each
		foreach (rows[i]) begin
			wbXfer(1'b1, scan_output_pkg::REG_CTRL, {30'h0, rows[i].ctrl});
			cpu_i.send(5'h13, rows[i].grp, rows[i].dat);
			cpu_i.idle();
			tick(2);
			check(fieldOut[8*rows[i].grp +: 8], rows[i].exp);
			check(ledOut[8*rows[i].grp +: 8], rows[i].exp);
			check(ledHold, rows[i].ctrl[0]);
			check(ledInvert, rows[i].ctrl[1]);
		end
		$display("test rows done");
		// Foreign block index is ignored
		cpu_i.send(5'h12, 2'h0, 8'hff);
		cpu_i.idle();
		tick(2);
		check(fieldOut[7:0], 8'ha5);
		wbXfer(1'b0, scan_output_pkg::REG_SLOT, 32'h0);
		check(rd, 32'h13);
		wbXfer(1'b0, 8'h18, 32'h0);
		check(rd, 32'h0);
		$display("test block select done");
		// Back-to-back full block raises the block event
		wbXfer(1'b1, scan_output_pkg::REG_CTRL, 32'h0);
		wbXfer(1'b1, scan_output_pkg::REG_IRQ_STAT, 32'h7);
		wbXfer(1'b1, scan_output_pkg::REG_IRQ_MASK, 32'h4);
		cpu_i.sendBlock(5'h13, 32'h8421_c3e7);
		tick(3);
		check(fieldOut, 32'h8421_c3e7);
		check(irq, 1'b1);
		wbXfer(1'b0, scan_output_pkg::REG_OUTPUTS, 32'h0);
		check(rd, 32'h8421_c3e7);
		wbXfer(1'b1, scan_output_pkg::REG_IRQ_STAT, 32'h4);
		tick(2);
		check(irq, 1'b0);
		$display("test full block done");
		// Hold mode keeps values through a fault and refuses data meanwhile
		wbXfer(1'b1, scan_output_pkg::REG_CTRL, 32'h1);
		cpu_i.fault(1'b1);
		cpu_i.send(5'h13, 2'h0, 8'h00);
		cpu_i.idle();
		tick(3);
		check(fieldOut, 32'h8421_c3e7);
		cpu_i.fault(1'b0);
		cpu_i.send(5'h13, 2'h0, 8'h11);
		cpu_i.idle();
		tick(2);
		check(fieldOut, 32'h8421_c311);
		// Disable mode clears on fault; fault event stays masked
		wbXfer(1'b1, scan_output_pkg::REG_CTRL, 32'h0);
		cpu_i.fault(1'b1);
		tick(3);
		check(fieldOut, 32'h0);
		check(irq, 1'b0);
		// Fault start recorded while masked; refused bytes left group bits unseen
		wbXfer(1'b0, scan_output_pkg::REG_IRQ_STAT, 32'h0);
		check(rd, 32'h2);
		cpu_i.fault(1'b0);
		$display("test fault modes done");
		// Missing supply: alarm, outputs off, interrupt raised then cleared
		cpu_i.sendBlock(5'h13, 32'hffff_ffff);
		wbXfer(1'b1, scan_output_pkg::REG_IRQ_STAT, 32'h7);
		wbXfer(1'b1, scan_output_pkg::REG_IRQ_MASK, 32'h1);
		supplyGroupsHigh <= 1'b0;
		tick(3);
		check(alarm, 1'b1);
		check(irq, 1'b1);
		check(fieldOut, 32'h0);
		check(ledOut, 32'h0);
		wbXfer(1'b0, scan_output_pkg::REG_STATUS, 32'h0);
		check(rd, 32'h9);
		supplyGroupsHigh <= 1'b1;
		tick(3);
		check(alarm, 1'b0);
		check(fieldOut, 32'h0);
		wbXfer(1'b1, scan_output_pkg::REG_IRQ_STAT, 32'h1);
		tick(2);
		check(irq, 1'b0);
		$display("test supply alarm done");
		endOfTest();
	end
endmodule // testbench
